//--- pkg/urw_pkg.sv
// Package for the serial port receive error, interrupt and wake logic.
// Assumes one 50 MHz system clock domain and an APB slave for registers.
package urw_pkg;
	localparam logic [11:0] URW_STATUS_OFS = 12'h000;
	localparam logic [11:0] URW_CTRL1_OFS  = 12'h004;
	localparam logic [11:0] URW_CTRL2_OFS  = 12'h008;
	localparam logic [11:0] URW_DATA_OFS   = 12'h00c;
	localparam logic [11:0] URW_GIE_OFS    = 12'h010;
	// Control two fields
	localparam int URW_C2_TXE_IE  = 0;
	localparam int URW_C2_TXI_IE  = 1;
	localparam int URW_C2_RX_IE   = 2;
	localparam int URW_C2_ADDR_EN = 3;
	localparam int URW_C2_WAKE_EN = 4;
	// Control one fields
	localparam int URW_C1_PORT_EN = 0;
	localparam int URW_C1_RX_EN   = 1;
	localparam int URW_C1_PAR_EN  = 2;
	localparam int URW_C1_PAR_ODD = 3;
	localparam int URW_C1_NINE    = 4;
	localparam int URW_C1_RX8     = 5;
	localparam logic [7:0] URW_CTRL_RST = 8'h00;
	localparam int URW_SETTLE_NS = 1000;
	localparam int URW_CLK_NS    = 20;
	localparam logic [7:0] URW_SETTLE_CYC = 8'((URW_SETTLE_NS + URW_CLK_NS - 1) / URW_CLK_NS);
	typedef struct packed {
		logic       valid;
		logic [8:0] data;
		logic       frame_err;
		logic       parity_bit;
	} urw_word_t;
endpackage : urw_pkg

//--- hw/urw_core.sv
// Receive errors, interrupt combine, address detect and wake logic.
// Assumes a receive shifter delivering words and pauses of core_clk_i.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module urw_core (
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire urw_pkg::urw_word_t rx_word_i,
	input  wire logic              overrun_i,
	input  wire logic              tx_empty_i,
	input  wire logic              tx_idle_i,
	input  wire logic              clk_stopped_i,
	input  wire logic              serial_receive_pin_i,
	input  wire logic              port_interrupt_enable_i,
	output logic                   wake_o,
	output logic                   irq_n_o
);
	import urw_pkg::*;

	logic [7:0] port_control_one_reg;
	logic [7:0] port_control_two_reg;
	logic       global_interrupt_enable_reg;
	logic       parity_error_flag_reg;
	logic       framing_error_flag_reg;
	logic       overrun_error_flag_reg;
	logic [8:0] buf_reg [0:1];
	logic [1:0] count_reg;
	logic       status_seen_reg;
	logic       pin_s1_reg;
	logic       pin_s2_reg;
	logic       pin_prev_reg;
	logic       wake_pend_reg;
	logic [7:0] settle_reg;
	logic       irq_n_reg;
	logic       rx_available_flag;
	logic       wr_en;
	logic       rd_en;
	logic       data_rd;
	logic       accept;
	logic       word_top;
	logic       addr_word;
	logic       rx_ev;
	logic       any_ev;
	logic       settling;
	logic       wake_ev;
	logic       wake_irq;
	logic [7:0] woke_cyc_reg;

	function automatic logic par_ok(input logic [8:0] d, input logic nine,
		input logic pb, input logic odd);
		logic p;
		p = ^(nine ? d : {1'b0, d[7:0]}) ^ pb;
		return odd ? p : ~p;
	endfunction : par_ok

	assign pready_o  = 1'b1;
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_en     = psel_i & penable_i & ~pwrite_i;
	assign data_rd   = rd_en & (paddr_i == URW_DATA_OFS);
	assign settling  = settle_reg != 8'h00;
	// Words arriving while the clock settles after a wake are dropped
	assign accept    = rx_word_i.valid & ~clk_stopped_i & ~settling;
	assign word_top  = port_control_one_reg[URW_C1_NINE] ? rx_word_i.data[8]
		: rx_word_i.data[7];
	assign addr_word = accept & word_top;
	assign rx_available_flag = count_reg != 2'd0;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pslverr_o <= 1'b0;
		end else if (psel_i & ~penable_i) begin
			pslverr_o <= !(paddr_i == URW_STATUS_OFS || paddr_i == URW_CTRL1_OFS
				|| paddr_i == URW_CTRL2_OFS || paddr_i == URW_DATA_OFS
				|| paddr_i == URW_GIE_OFS);
		end
	end

	// Registers hold through clock stop unless written over APB: received words do not touch RX8 then
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			port_control_one_reg        <= URW_CTRL_RST;
			port_control_two_reg        <= URW_CTRL_RST;
			global_interrupt_enable_reg <= 1'b0;
		end else begin
			if (wr_en && paddr_i == URW_CTRL1_OFS) begin
				port_control_one_reg[4:0] <= pwdata_i[4:0];
			end
			if (accept && port_control_one_reg[URW_C1_NINE]) begin
				port_control_one_reg[URW_C1_RX8] <= rx_word_i.data[8];
			end
			if (wr_en && paddr_i == URW_CTRL2_OFS) begin
				port_control_two_reg <= pwdata_i[7:0];
			end
			if (wr_en && paddr_i == URW_GIE_OFS) begin
				global_interrupt_enable_reg <= pwdata_i[0];
			end
		end
	end

	// Two-word receive buffer; a third word is dropped as overrun
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_reg  <= 2'd0;
			buf_reg[0] <= 9'h000;
			buf_reg[1] <= 9'h000;
		end else begin
			if (data_rd && count_reg != 2'd0) begin
				buf_reg[0] <= (accept && count_reg == 2'd1) ? rx_word_i.data : buf_reg[1];
				if (!accept) begin
					count_reg <= count_reg - 2'd1;
				end else if (count_reg == 2'd2) begin
					buf_reg[1] <= rx_word_i.data;
				end
			end else if (accept && count_reg != 2'd2) begin
				buf_reg[count_reg[0]] <= rx_word_i.data;
				count_reg <= count_reg + 2'd1;
			end
		end
	end

	// Overrun clears only by status read then data read, set wins; parity and framing reload on each accepted word
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			parity_error_flag_reg  <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			overrun_error_flag_reg <= 1'b0;
			status_seen_reg        <= 1'b0;
		end else begin
			if (rd_en && paddr_i == URW_STATUS_OFS) begin
				status_seen_reg <= 1'b1;
			end else if (data_rd) begin
				status_seen_reg <= 1'b0;
			end
			if (accept) begin
				parity_error_flag_reg <= port_control_one_reg[URW_C1_PAR_EN]
					& ~par_ok(rx_word_i.data, port_control_one_reg[URW_C1_NINE],
					rx_word_i.parity_bit, port_control_one_reg[URW_C1_PAR_ODD]);
				framing_error_flag_reg <= rx_word_i.frame_err;
			end else if (data_rd && status_seen_reg) begin
				parity_error_flag_reg  <= 1'b0;
				framing_error_flag_reg <= 1'b0;
			end
			if (overrun_i || (accept && count_reg == 2'd2 && !data_rd)) begin
				overrun_error_flag_reg <= 1'b1;
			end else if (data_rd && status_seen_reg) begin
				overrun_error_flag_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		prdata_o = 32'h0000_0000;
		if (paddr_i == URW_STATUS_OFS) begin
			prdata_o[5:0] = {tx_idle_i, tx_empty_i, rx_available_flag,
				overrun_error_flag_reg, framing_error_flag_reg, parity_error_flag_reg};
		end else if (paddr_i == URW_CTRL1_OFS) begin
			prdata_o[7:0] = port_control_one_reg;
		end else if (paddr_i == URW_CTRL2_OFS) begin
			prdata_o[7:0] = port_control_two_reg;
		end else if (paddr_i == URW_DATA_OFS) begin
			prdata_o[8:0] = buf_reg[0];
		end else if (paddr_i == URW_GIE_OFS) begin
			prdata_o[0] = global_interrupt_enable_reg;
		end
	end

	// Wake detector; pin is synchronised first
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pin_s1_reg    <= 1'b1;
			pin_s2_reg    <= 1'b1;
			pin_prev_reg  <= 1'b1;
			wake_pend_reg <= 1'b0;
			settle_reg    <= 8'h00;
		end else begin
			pin_s1_reg   <= serial_receive_pin_i;
			pin_s2_reg   <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
			if (wake_ev) begin
				settle_reg    <= URW_SETTLE_CYC;
				wake_pend_reg <= global_interrupt_enable_reg & port_interrupt_enable_i;
			end else if (settling && !clk_stopped_i) begin
				settle_reg <= settle_reg - 8'h01;
			end else if (!settling) begin
				wake_pend_reg <= 1'b0;
			end
		end
	end

	assign wake_ev = clk_stopped_i & pin_prev_reg & ~pin_s2_reg
		& port_control_two_reg[URW_C2_WAKE_EN] & port_control_one_reg[URW_C1_PORT_EN]
		& port_control_one_reg[URW_C1_RX_EN] & port_control_two_reg[URW_C2_RX_IE];
	assign wake_o  = wake_ev;

	// Receive word event, qualified by address mode
	assign rx_ev = port_control_two_reg[URW_C2_RX_IE] & ((accept
		& (~port_control_two_reg[URW_C2_ADDR_EN] | (addr_word
		& port_interrupt_enable_i & global_interrupt_enable_reg))) | overrun_i);
	assign wake_irq = wake_pend_reg & ~settling;
	assign any_ev = rx_ev
		| (tx_empty_i & port_control_two_reg[URW_C2_TXE_IE] & ~clk_stopped_i)
		| (tx_idle_i & port_control_two_reg[URW_C2_TXI_IE] & ~clk_stopped_i)
		| (addr_word & port_control_two_reg[URW_C2_ADDR_EN]
			& port_interrupt_enable_i & global_interrupt_enable_reg)
		| wake_irq;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			irq_n_reg <= 1'b1;
		end else begin
			// An event in the low cycle merges into it, it is not queued
			irq_n_reg <= ~(any_ev & irq_n_reg);
		end
	end
	assign irq_n_o = irq_n_reg;

	AST_IRQ_ONE_CYCLE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!irq_n_o |=> irq_n_o) else $error("interrupt low longer than one cycle");
	AST_PAR_RESET: assert property (@(posedge core_clk_i)
		reset_i |=> !parity_error_flag_reg) else $error("parity flag not cleared");
	AST_PAR_DISABLED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !port_control_one_reg[URW_C1_PAR_EN] |=> !parity_error_flag_reg)
		else $error("parity flag set while disabled");
	AST_RXAVAIL: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && count_reg == 2'd0 |=> rx_available_flag) else $error("rx flag missing");
	AST_SETTLE_DROP: assert property (@(posedge core_clk_i) disable iff (reset_i)
		settling && !data_rd |=> count_reg <= $past(count_reg)) else $error("data kept in settle");
	AST_ADDR_GATE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && port_control_two_reg[URW_C2_ADDR_EN] && !word_top && !overrun_i
		&& port_control_two_reg[URW_C2_RX_IE] |-> !rx_ev)
		else $error("data interrupt in address mode");
	AST_WAKE_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wake_ev |=> settling) else $error("wake skipped settle");
	AST_WAKE_NOIRQ: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wake_ev && !global_interrupt_enable_reg |=> !wake_pend_reg)
		else $error("wake interrupt without enables");
	AST_CTRL_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		clk_stopped_i && !wr_en |=> port_control_two_reg == $past(port_control_two_reg))
		else $error("control changed in power-down");
	AST_CTRL1_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		clk_stopped_i && !wr_en |=> port_control_one_reg == $past(port_control_one_reg))
		else $error("control one changed in power-down");

	// Interrupt combine and the receive qualifiers
	AST_IRQ_ISSUE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		any_ev && irq_n_o |=> !irq_n_o) else $error("event gave no interrupt pulse");
	AST_IRQ_QUIET: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!any_ev |=> irq_n_o) else $error("interrupt pulse without event");
	AST_EVERY_WORD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && port_control_two_reg[URW_C2_RX_IE] && !port_control_two_reg[URW_C2_ADDR_EN]
		|-> rx_ev) else $error("word gave no data interrupt");
	AST_ADDR_ENABLES: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && port_control_two_reg[URW_C2_ADDR_EN] && !overrun_i
		&& !(port_interrupt_enable_i && global_interrupt_enable_reg) |-> !rx_ev)
		else $error("address interrupt without enables");
	AST_OVR_EVENT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		overrun_i && port_control_two_reg[URW_C2_RX_IE] |-> any_ev)
		else $error("overrun gave no interrupt");

	// Status flags, ninth bit and buffer count
	AST_PAR_SET: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && port_control_one_reg[URW_C1_PAR_EN] && !par_ok(rx_word_i.data,
		port_control_one_reg[URW_C1_NINE], rx_word_i.parity_bit,
		port_control_one_reg[URW_C1_PAR_ODD]) |=> parity_error_flag_reg)
		else $error("parity error not flagged");
	AST_FLAG_KEEP: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!accept && !overrun_i && !(data_rd && status_seen_reg)
		|=> $stable({parity_error_flag_reg, framing_error_flag_reg, overrun_error_flag_reg}))
		else $error("status flag changed without cause");
	AST_NINTH_BIT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && port_control_one_reg[URW_C1_NINE]
		|=> port_control_one_reg[URW_C1_RX8] == $past(word_top))
		else $error("ninth bit not stored");
	AST_BUF_BOUND: assert property (@(posedge core_clk_i) disable iff (reset_i)
		count_reg != 2'd3) else $error("receive buffer count out of range");

	// Cycles with the clock running since the last wake, for the settle check
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			woke_cyc_reg <= 8'h00;
		end else if (wake_ev) begin
			woke_cyc_reg <= 8'h00;
		end else if (!clk_stopped_i && woke_cyc_reg != 8'hff) begin
			woke_cyc_reg <= woke_cyc_reg + 8'h01;
		end
	end

	AST_SETTLE_LOAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wake_ev |=> settle_reg == URW_SETTLE_CYC) else $error("settle count not loaded");
	AST_WAKE_LATE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wake_irq |-> woke_cyc_reg >= URW_SETTLE_CYC) else $error("wake interrupt before settle");
	AST_WAKE_PEND: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wake_ev && global_interrupt_enable_reg && port_interrupt_enable_i |=> wake_pend_reg)
		else $error("wake interrupt lost");

	COV_WAKE: cover property (@(posedge core_clk_i) wake_ev ##[1:150] !irq_n_o);
	COV_OVERRUN: cover property (@(posedge core_clk_i) overrun_error_flag_reg);
	COV_ADDR: cover property (@(posedge core_clk_i) addr_word && !irq_n_reg);
	COV_PARITY: cover property (@(posedge core_clk_i) $rose(parity_error_flag_reg));
	COV_SETTLE_DROP: cover property (@(posedge core_clk_i) rx_word_i.valid && settling);
endmodule : urw_core
`default_nettype wire

//--- tb/urw_far_tx.sv
// Far-end model: a remote transmitter as seen after the receive shifter.
// Assumes words arrive as one-cycle valid pulses on the word struct.
`timescale 1ns/1ps
`default_nettype none
module urw_far_tx (
	input  wire logic          clk_i,
	output urw_pkg::urw_word_t word_o,
	output logic               overrun_o,
	output logic               pin_o
);
	import urw_pkg::*;
	// Idle line is high, as a stop level
	initial begin
		word_o = '0;
		overrun_o = 1'b0;
		pin_o = 1'b1;
	end
	task automatic send(input logic [8:0] d, input logic pb);
		@(posedge clk_i);
		word_o <= {1'b1, d, 1'b0, pb};
		@(posedge clk_i);
		// Released lines show garbage, never the old word
		word_o <= {1'b0, ~d, 1'b1, ~pb};
	endtask : send
	task automatic ovr();
		@(posedge clk_i);
		overrun_o <= 1'b1;
		@(posedge clk_i);
		overrun_o <= 1'b0;
	endtask : ovr
	task automatic pin(input logic v);
		@(posedge clk_i);
		pin_o <= v;
	endtask : pin
endmodule : urw_far_tx
`default_nettype wire

//--- tb/tb.sv
// Bench for the receive error, interrupt and wake block.
// Assumes an APB slave that answers with pready and the far-end model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import urw_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        txe = 0, txi = 0, stop = 0, pie = 1, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, wake, irq_n, ovr, pin;
	urw_word_t   word;
	int          fails = 0, compares = 0, lows = 0, wakes = 0;
	logic [8:0]  ad_d [5] = '{9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h080};
	logic [2:0]  ad_m [5] = '{3'b001, 3'b011, 3'b101, 3'b111, 3'b000};
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (irq_n === 1'b0) lows++;
		if (wake === 1'b1) wakes++;
	end
	urw_far_tx i_far (.clk_i(clk), .word_o(word), .overrun_o(ovr), .pin_o(pin));
	urw_core i_dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rx_word_i(word), .overrun_i(ovr),
		.tx_empty_i(txe), .tx_idle_i(txi), .clk_stopped_i(stop),
		.serial_receive_pin_i(pin), .port_interrupt_enable_i(pie), .wake_o(wake),
		.irq_n_o(irq_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(rd, exp);
	endtask : rdc
	task automatic win(input int cyc, input int exp);
		repeat (cyc) @(posedge clk);
		chk(32'(lows), 32'(exp));
		lows = 0;
	endtask : win
	// Status then data read, as software must do before taking a word
	task automatic flush();
		apb(1'b0, URW_STATUS_OFS, '0);
		apb(1'b0, URW_DATA_OFS, '0);
	endtask : flush
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(URW_STATUS_OFS, 32'h0);
		rdc(URW_CTRL1_OFS, 32'h0);
		rdc(URW_CTRL2_OFS, 32'h0);
		apb(1'b0, 12'h014, '0);
		chk(err, 1'b1);
		apb(1'b1, URW_GIE_OFS, 32'h1);
		apb(1'b1, URW_CTRL1_OFS, 32'h07);
		apb(1'b1, URW_CTRL2_OFS, 32'h04);
		lows = 0;
		i_far.send(9'h003, 1'b1);
		win(6, 1);
		rdc(URW_STATUS_OFS, 32'h09);
		apb(1'b1, URW_STATUS_OFS, 32'h0);
		rdc(URW_STATUS_OFS, 32'h09);
		rdc(URW_DATA_OFS, 32'h03);
		rdc(URW_STATUS_OFS, 32'h0);
		apb(1'b1, URW_CTRL1_OFS, 32'h0f);
		i_far.send(9'h003, 1'b1);
		rdc(URW_STATUS_OFS, 32'h08);
		flush();
		apb(1'b1, URW_CTRL2_OFS, 32'h0);
		lows = 0;
		i_far.send(9'h005, 1'b0);
		win(6, 0);
		flush();
		apb(1'b1, URW_CTRL2_OFS, 32'h04);
		lows = 0;
		i_far.ovr();
		win(6, 1);
		rdc(URW_STATUS_OFS, 32'h04);
		flush();
		// Parity off after address mode is on; the two cannot share
		apb(1'b1, URW_CTRL2_OFS, 32'h0c);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, URW_CTRL1_OFS, ad_m[i][2] ? 32'h13 : 32'h03);
			apb(1'b1, URW_GIE_OFS, 32'(ad_m[i][0]));
			lows = 0;
			i_far.send(ad_d[i], 1'b0);
			win(6, ad_m[i][1]);
			if (i == 3) rdc(URW_CTRL1_OFS, 32'h33);
			flush();
		end
		apb(1'b1, URW_GIE_OFS, 32'h1);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, URW_CTRL2_OFS, 32'(1 << i));
			lows = 0;
			if (i == 0) txe <= 1'b1;
			else txi <= 1'b1;
			repeat (10) @(posedge clk);
			chk(lows > 0, 1'b1);
			txe <= 1'b0;
			txi <= 1'b0;
		end
		apb(1'b1, URW_CTRL2_OFS, 32'h02);
		lows = 0;
		txe <= 1'b1;
		win(10, 0);
		txe <= 1'b0;
		apb(1'b1, URW_CTRL2_OFS, 32'h14);
		stop <= 1'b1;
		rdc(URW_CTRL2_OFS, 32'h14);
		for (int g = 1; g >= 0; g--) begin
			apb(1'b1, URW_GIE_OFS, 32'(g));
			stop <= 1'b1;
			lows = 0;
			wakes = 0;
			i_far.send(9'h0aa, 1'b0);
			i_far.pin(1'b0);
			win(40, 0);
			chk(32'(wakes), 32'h1);
			// Clock back: the settle count now runs down
			stop <= 1'b0;
			i_far.send(9'h055, 1'b0);
			win(43, 0);
			win(15, g);
			rdc(URW_STATUS_OFS, 32'h0);
			i_far.pin(1'b1);
			repeat (4) @(posedge clk);
		end
		stop <= 1'b0;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
